// File: design/syp_consts.svh
`ifndef SYP_CONSTS_SVH
`define SYP_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SYP_OFS_CTRL 8'h00
`define SYP_OFS_STAT 8'h04
`define SYP_OFS_BUF 8'h08
`define SYP_OFS_DIR 8'h0C
`define SYP_OFS_IST 8'h10
`define SYP_OFS_IMASK 8'h14

// ****************************************
// Field positions
// ****************************************
`define SYP_CTRL_WRITE_COLLISION_FLAG 7
`define SYP_CTRL_EN 5
`define SYP_CTRL_CPOL 4
`define SYP_STAT_SMP 7
`define SYP_STAT_CKE 6
`define SYP_DIR_SDI 0
`define SYP_DIR_SDO 1
`define SYP_DIR_SCK 2
`define SYP_DIR_SS 3
`define SYP_IRQ_BYTE 0
`define SYP_IRQ_WRITE_COLLISION_FLAG 1

// ****************************************
// Mode codes and reset values
// ****************************************
`define SYP_MODE_M4 4'h0
`define SYP_MODE_M16 4'h1
`define SYP_MODE_M64 4'h2
`define SYP_MODE_SLV_SS 4'h4
`define SYP_MODE_SLV 4'h5
`define SYP_DIR_RST 4'hF

// ****************************************
// Half periods in aclk cycles, last edge and last bit indices
// ****************************************
`define SYP_HALF_M4 6'h02
`define SYP_HALF_M16 6'h08
`define SYP_HALF_M64 6'h20
`define SYP_LAST_EDGE 5'h10
`define SYP_LAST_BIT 4'h7
`endif

// File: design/syp_pkg.sv
package syp_pkg;

    // Transfer engine state
    typedef enum logic {SYP_IDLE, SYP_RUN} syp_state_t;

    // Device state, registered as one group
    typedef struct packed {
        syp_state_t state;
        logic en;
        logic cpol;
        logic [3:0] mode;
        logic smp;
        logic cke;
        logic write_collision_flag;
        logic bf;
        logic [7:0] buffer;
        logic [7:0] sr;
        logic out_bit;
        logic [3:0] nbits;
        logic [4:0] k;
        logic [5:0] div;
        logic sck;
        logic ss_n;
        logic [3:0] dir;
        logic [1:0] ist;
        logic [1:0] imask;
        logic irq;
        logic wake;
        logic sdo_oe;
        logic sck_oe;
        logic ss_oe;
        logic awready;
        logic wready;
        logic aw_ok;
        logic w_ok;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } syp_dev_t;

    // Partner state
    typedef struct packed {
        syp_state_t state;
        logic [7:0] sr;
        logic out_bit;
        logic [3:0] nbits;
        logic [4:0] k;
        logic [7:0] div;
        logic sck;
        logic ss_n;
        logic sdo_oe;
        logic sck_oe;
        logic ss_oe;
        logic [7:0] rx_byte;
        logic rx_valid;
        logic busy;
    } syp_ptn_t;

endpackage

// File: design/syp_link_if.sv
`timescale 1ns/10ps
// Serial link between the port and its partner
interface syp_link_if;
    logic dev_sdo, dev_sdo_oe, dev_sck_o, dev_sck_oe, dev_ss_n_o, dev_ss_oe;
    logic ptn_sdo, ptn_sdo_oe, ptn_sck_o, ptn_sck_oe, ptn_ss_n_o, ptn_ss_oe;
    logic dev_sdi, ptn_sdi, sck, ss_n;

    // Wire levels from the enables; undriven lines read low, select reads high
    assign sck = dev_sck_oe ? dev_sck_o : (ptn_sck_oe ? ptn_sck_o : 1'b0);
    assign ss_n = dev_ss_oe ? dev_ss_n_o : (ptn_ss_oe ? ptn_ss_n_o : 1'b1);
    assign dev_sdi = ptn_sdo_oe ? ptn_sdo : 1'b0;
    assign ptn_sdi = dev_sdo_oe ? dev_sdo : 1'b0;

    modport dev (output dev_sdo, dev_sdo_oe, dev_sck_o, dev_sck_oe, dev_ss_n_o,
        dev_ss_oe, input dev_sdi, sck, ss_n);
    modport ptn (output ptn_sdo, ptn_sdo_oe, ptn_sck_o, ptn_sck_oe, ptn_ss_n_o,
        ptn_ss_oe, input ptn_sdi, sck, ss_n);
endinterface

// File: design/syp_port.sv
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "syp_consts.svh"
module syp_port (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // System
    input wire logic sleep,
    output logic irq,
    output logic wake,
    // Serial link
    syp_link_if.dev link
);
    import syp_pkg::*;

    // Reset image of the state group
    localparam syp_dev_t RST = '{state: SYP_IDLE, dir: `SYP_DIR_RST, ss_n: 1'b1,
        default: '0};

    // ****************************************
    // Decoders
    // ****************************************
    // Master modes give a half period, zero otherwise
    function automatic logic [5:0] half_of(input logic [3:0] m);
        if (m == `SYP_MODE_M4) begin
            half_of = `SYP_HALF_M4;
        end else if (m == `SYP_MODE_M16) begin
            half_of = `SYP_HALF_M16;
        end else if (m == `SYP_MODE_M64) begin
            half_of = `SYP_HALF_M64;
        end else begin
            half_of = 6'h00;
        end
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] sdi_s_reg, sck_s_reg, ss_s_reg; // [0] first, [1] second, [2] edge copy
    logic [2:0] sdi_s_next, sck_s_next, ss_s_next;
    syp_dev_t r_reg, r_next; // All device state

    // Shift pins through two stages plus an edge copy
    always_comb begin
        sdi_s_next = {sdi_s_reg[1:0], link.dev_sdi};
        sck_s_next = {sck_s_reg[1:0], link.sck};
        ss_s_next = {ss_s_reg[1:0], link.ss_n};
    end

    // Register synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sdi_s_reg <= 3'h0;
            sck_s_reg <= 3'h0;
            ss_s_reg <= 3'h7;
        end else if (ce) begin
            sdi_s_reg <= sdi_s_next;
            sck_s_reg <= sck_s_next;
            ss_s_reg <= ss_s_next;
        end
    end

    // ****************************************
    // Next state of bus, registers and engine
    // ****************************************
    logic master, slave, sdi_ok, sdo_ok, sck_ok, ss_mode, selected, busy;
    logic sck_rise, sck_fall, lead, trail, out_ev, smp_ev, op, tick;
    logic sdi;
    logic [5:0] half;

    // Next values of the whole state group
    always_comb begin
        r_next = r_reg;
        half = half_of(r_reg.mode);
        master = (half != 6'h00);
        slave = (r_reg.mode == `SYP_MODE_SLV_SS) || (r_reg.mode == `SYP_MODE_SLV);
        // Direction checks per pin
        sdi_ok = r_reg.dir[`SYP_DIR_SDI];
        sdo_ok = !r_reg.dir[`SYP_DIR_SDO];
        sck_ok = master ? !r_reg.dir[`SYP_DIR_SCK] : r_reg.dir[`SYP_DIR_SCK];
        ss_mode = (r_reg.mode == `SYP_MODE_SLV_SS) && r_reg.dir[`SYP_DIR_SS];
        selected = !ss_mode || !ss_s_reg[1];
        sdi = sdi_ok & sdi_s_reg[1];
        sck_rise = sck_s_reg[1] & ~sck_s_reg[2];
        sck_fall = ~sck_s_reg[1] & sck_s_reg[2];
        lead = r_reg.cpol ? sck_fall : sck_rise;
        trail = r_reg.cpol ? sck_rise : sck_fall;
        op = r_reg.cke;
        busy = (r_reg.state == SYP_RUN) || (r_reg.nbits != 4'h0);
        out_ev = 1'b0;
        smp_ev = 1'b0;
        tick = 1'b0;
        r_next.arready = 1'b0;

        // Write channel handshakes, either order
        if (r_reg.awready && s_axi_awvalid) begin
            r_next.aw_ok = 1'b1;
            r_next.awaddr = s_axi_awaddr;
        end
        if (r_reg.wready && s_axi_wvalid) begin
            r_next.w_ok = 1'b1;
            r_next.wdata = s_axi_wdata;
            r_next.wstrb0 = s_axi_wstrb[0];
        end
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end
        // Register write once address and data are both held
        if (r_reg.aw_ok && r_reg.w_ok && !r_reg.bvalid) begin
            r_next.aw_ok = 1'b0;
            r_next.w_ok = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = 2'h0;
            if (!r_reg.wstrb0) begin
                // No lane for the low byte: nothing stored
            end else if (r_reg.awaddr == `SYP_OFS_CTRL) begin
                if (!r_reg.wdata[`SYP_CTRL_WRITE_COLLISION_FLAG]) begin
                    r_next.write_collision_flag = 1'b0;
                end
                r_next.en = r_reg.wdata[`SYP_CTRL_EN];
                if (!r_reg.en) begin
                    r_next.cpol = r_reg.wdata[`SYP_CTRL_CPOL];
                    r_next.mode = r_reg.wdata[3:0];
                end
            end else if (r_reg.awaddr == `SYP_OFS_STAT) begin
                if (!r_reg.en) begin
                    r_next.smp = r_reg.wdata[`SYP_STAT_SMP];
                    r_next.cke = r_reg.wdata[`SYP_STAT_CKE];
                end
            end else if (r_reg.awaddr == `SYP_OFS_BUF) begin
                if (busy || r_reg.write_collision_flag) begin
                    r_next.write_collision_flag = 1'b1;
                    r_next.ist[`SYP_IRQ_WRITE_COLLISION_FLAG] = 1'b1;
                end else begin
                    r_next.sr = r_reg.wdata[7:0];
                    r_next.out_bit = r_reg.wdata[7];
                    if (r_reg.en && master && sck_ok) begin
                        r_next.state = SYP_RUN;
                        r_next.k = 5'h00;
                        r_next.div = 6'h00;
                        r_next.ss_n = 1'b0;
                    end
                end
            end else if (r_reg.awaddr == `SYP_OFS_DIR) begin
                r_next.dir = r_reg.wdata[3:0];
            end else if (r_reg.awaddr == `SYP_OFS_IST) begin
                r_next.ist = r_reg.ist & ~r_reg.wdata[1:0];
            end else if (r_reg.awaddr == `SYP_OFS_IMASK) begin
                r_next.imask = r_reg.wdata[1:0];
            end else begin
                r_next.bresp = 2'h2;
            end
        end
        r_next.awready = !r_next.aw_ok && !r_next.bvalid;
        r_next.wready = !r_next.w_ok && !r_next.bvalid;

        // Read channel: address taken, data one cycle later
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !r_reg.arready && !r_reg.rvalid) begin
            r_next.arready = 1'b1;
        end
        if (r_reg.arready && s_axi_arvalid) begin
            r_next.rvalid = 1'b1;
            r_next.rresp = 2'h0;
            r_next.rdata = 32'h0000_0000;
            if (s_axi_araddr == `SYP_OFS_CTRL) begin
                r_next.rdata[7:0] = {r_reg.write_collision_flag, 1'b0, r_reg.en, r_reg.cpol, r_reg.mode};
            end else if (s_axi_araddr == `SYP_OFS_STAT) begin
                // Clock pin level lets software check idle before enable
                r_next.rdata[7:0] = {r_reg.smp, r_reg.cke, 3'h0, sck_s_reg[1], busy,
                    r_reg.bf};
            end else if (s_axi_araddr == `SYP_OFS_BUF) begin
                r_next.rdata[7:0] = r_reg.buffer;
                r_next.bf = 1'b0;
            end else if (s_axi_araddr == `SYP_OFS_DIR) begin
                r_next.rdata[3:0] = r_reg.dir;
            end else if (s_axi_araddr == `SYP_OFS_IST) begin
                r_next.rdata[1:0] = r_reg.ist;
            end else if (s_axi_araddr == `SYP_OFS_IMASK) begin
                r_next.rdata[1:0] = r_reg.imask;
            end else begin
                r_next.rresp = 2'h2;
            end
        end

        // Master clock generator: 16 edges, then a closing half period
        if (r_reg.state == SYP_RUN) begin
            if (r_reg.div == half - 6'h01) begin
                r_next.div = 6'h00;
                tick = 1'b1;
                r_next.k = r_reg.k + 5'h01;
                if (r_reg.k != `SYP_LAST_EDGE) begin
                    r_next.sck = ~r_reg.sck;
                end else begin
                    r_next.state = SYP_IDLE;
                    r_next.ss_n = 1'b1;
                    r_next.k = 5'h00;
                end
            end else begin
                r_next.div = r_reg.div + 6'h01;
            end
            out_ev = tick && (r_reg.k[0] == op) && (r_reg.k != `SYP_LAST_EDGE);
            if (r_reg.smp) begin
                smp_ev = tick && (r_reg.k[0] == op) && (r_reg.k != 5'h00);
            end else begin
                smp_ev = tick && (r_reg.k[0] != op) && (r_reg.k != `SYP_LAST_EDGE);
            end
        end else if (r_reg.en && slave && sck_ok && selected) begin
            // Slave follows external clock edges, also during sleep
            out_ev = op ? trail : lead;
            smp_ev = op ? lead : trail;
        end

        // Shift: capture into LSB, present MSB
        if (smp_ev) begin
            r_next.sr = {r_next.sr[6:0], sdi};
            r_next.nbits = r_reg.nbits + 4'h1;
            if (r_reg.nbits == `SYP_LAST_BIT) begin
                r_next.nbits = 4'h0;
                r_next.buffer = r_next.sr;
                r_next.bf = 1'b1;
                r_next.ist[`SYP_IRQ_BYTE] = 1'b1;
            end
        end
        if (out_ev) begin
            r_next.out_bit = r_next.sr[7];
        end
        // Deselected slave drops any partial byte
        if (slave && ss_mode && ss_s_reg[1]) begin
            r_next.nbits = 4'h0;
        end
        // Disabled port idles everything
        if (!r_reg.en) begin
            r_next.state = SYP_IDLE;
            r_next.nbits = 4'h0;
            r_next.k = 5'h00;
            r_next.ss_n = 1'b1;
        end
        if (r_next.state == SYP_IDLE) begin
            r_next.sck = r_next.cpol;
        end
        // Pin enables and interrupt outputs
        r_next.sdo_oe = r_reg.en && sdo_ok && (master || (slave && selected));
        r_next.sck_oe = r_reg.en && master && sck_ok;
        r_next.ss_oe = r_reg.en && master;
        r_next.irq = |(r_next.ist & r_next.imask);
        r_next.wake = sleep && r_next.irq;
    end

    // Register the state group
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= RST;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    // ****************************************
    // Outputs, all straight from flops
    // ****************************************
    assign s_axi_awready = r_reg.awready;
    assign s_axi_wready = r_reg.wready;
    assign s_axi_bvalid = r_reg.bvalid;
    assign s_axi_bresp = r_reg.bresp;
    assign s_axi_arready = r_reg.arready;
    assign s_axi_rvalid = r_reg.rvalid;
    assign s_axi_rdata = r_reg.rdata;
    assign s_axi_rresp = r_reg.rresp;
    assign irq = r_reg.irq;
    assign wake = r_reg.wake;
    assign link.dev_sdo = r_reg.out_bit;
    assign link.dev_sdo_oe = r_reg.sdo_oe;
    assign link.dev_sck_o = r_reg.sck;
    assign link.dev_sck_oe = r_reg.sck_oe;
    assign link.dev_ss_n_o = r_reg.ss_n;
    assign link.dev_ss_oe = r_reg.ss_oe;
endmodule

// File: design/syp_partner.sv
`timescale 1ns/10ps
`include "syp_consts.svh"
module syp_partner #(
    parameter logic [7:0] HALF_CYC = 8'h08 // Half period of clock made as master
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Configuration, held steady while busy
    input wire logic is_master,
    input wire logic cpol,
    input wire logic cke,
    // User side
    input wire logic [7:0] tx_byte,
    input wire logic tx_start,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic busy,
    // Serial link
    syp_link_if.ptn link
);
    import syp_pkg::*;

    localparam syp_ptn_t RST = '{state: SYP_IDLE, ss_n: 1'b1, default: '0};

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] sdi_s_reg, sck_s_reg, ss_s_reg; // [0] first, [1] second, [2] edge copy
    logic [2:0] sdi_s_next, sck_s_next, ss_s_next;
    syp_ptn_t r_reg, r_next; // All partner state

    // Shift pins through two stages plus an edge copy
    always_comb begin
        sdi_s_next = {sdi_s_reg[1:0], link.ptn_sdi};
        sck_s_next = {sck_s_reg[1:0], link.sck};
        ss_s_next = {ss_s_reg[1:0], link.ss_n};
    end

    // Register synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sdi_s_reg <= 3'h0;
            sck_s_reg <= 3'h0;
            ss_s_reg <= 3'h7;
        end else if (ce) begin
            sdi_s_reg <= sdi_s_next;
            sck_s_reg <= sck_s_next;
            ss_s_reg <= ss_s_next;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    logic lead, trail, out_ev, smp_ev, tick;

    always_comb begin
        r_next = r_reg;
        r_next.rx_valid = 1'b0;
        lead = cpol ? (~sck_s_reg[1] & sck_s_reg[2]) : (sck_s_reg[1] & ~sck_s_reg[2]);
        trail = cpol ? (sck_s_reg[1] & ~sck_s_reg[2]) : (~sck_s_reg[1] & sck_s_reg[2]);
        out_ev = 1'b0;
        smp_ev = 1'b0;
        tick = 1'b0;
        // Load a new byte only between transfers
        if (tx_start && !r_reg.busy) begin
            r_next.sr = tx_byte;
            r_next.out_bit = tx_byte[7];
            if (is_master) begin
                r_next.state = SYP_RUN;
                r_next.k = 5'h00;
                r_next.div = 8'h00;
                r_next.ss_n = 1'b0;
            end
        end
        if (r_reg.state == SYP_RUN) begin
            // Make the clock: 16 edges then a closing half period
            if (r_reg.div == HALF_CYC - 8'h01) begin
                r_next.div = 8'h00;
                tick = 1'b1;
                r_next.k = r_reg.k + 5'h01;
                if (r_reg.k != `SYP_LAST_EDGE) begin
                    r_next.sck = ~r_reg.sck;
                end else begin
                    r_next.state = SYP_IDLE;
                    r_next.ss_n = 1'b1;
                    r_next.k = 5'h00;
                end
            end else begin
                r_next.div = r_reg.div + 8'h01;
            end
            out_ev = tick && (r_reg.k[0] == cke) && (r_reg.k != `SYP_LAST_EDGE);
            smp_ev = tick && (r_reg.k[0] != cke) && (r_reg.k != `SYP_LAST_EDGE);
        end else if (!is_master && !ss_s_reg[1]) begin
            out_ev = cke ? trail : lead;
            smp_ev = cke ? lead : trail;
        end
        if (smp_ev) begin
            r_next.sr = {r_next.sr[6:0], sdi_s_reg[1]};
            r_next.nbits = r_reg.nbits + 4'h1;
            if (r_reg.nbits == `SYP_LAST_BIT) begin
                r_next.nbits = 4'h0;
                r_next.rx_byte = r_next.sr;
                r_next.rx_valid = 1'b1;
            end
        end
        if (out_ev) begin
            r_next.out_bit = r_next.sr[7];
        end
        if (!is_master && ss_s_reg[1]) begin
            r_next.nbits = 4'h0;
        end
        if (r_next.state == SYP_IDLE) begin
            r_next.sck = cpol;
        end
        r_next.busy = (r_next.state == SYP_RUN) || (r_next.nbits != 4'h0);
        r_next.sdo_oe = is_master || !ss_s_reg[1];
        r_next.sck_oe = is_master;
        r_next.ss_oe = is_master;
    end

    // Register the state group
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= RST;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    // ****************************************
    // Outputs, all straight from flops
    // ****************************************
    assign rx_byte = r_reg.rx_byte;
    assign rx_valid = r_reg.rx_valid;
    assign busy = r_reg.busy;
    assign link.ptn_sdo = r_reg.out_bit;
    assign link.ptn_sdo_oe = r_reg.sdo_oe;
    assign link.ptn_sck_o = r_reg.sck;
    assign link.ptn_sck_oe = r_reg.sck_oe;
    assign link.ptn_ss_n_o = r_reg.ss_n;
    assign link.ptn_ss_oe = r_reg.ss_oe;
endmodule

// File: sim/syp_monitor.sv
`timescale 1ns/10ps
// ****
// Link checker
// ****
module syp_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link wires
    input wire logic dev_sdo_oe,
    input wire logic dev_sck_o,
    input wire logic dev_sck_oe,
    input wire logic dev_ss_oe,
    input wire logic ptn_sck_o,
    input wire logic ptn_sck_oe,
    input wire logic ptn_ss_oe,
    input wire logic sck,
    input wire logic ss_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Clock edges seen inside the current frame
    logic sck_reg, sck_next;
    logic [4:0] cnt_reg, cnt_next;
    always_comb begin
        sck_next = sck;
        cnt_next = ss_n ? 5'h00 : cnt_reg + 5'(sck != sck_reg);
    end
    always_ff @(posedge aclk) begin
        sck_reg <= sck_next;
        cnt_reg <= cnt_next;
    end
    property p_sck_one; !(dev_sck_oe && ptn_sck_oe); endproperty
    property p_ss_one; !(dev_ss_oe && ptn_ss_oe); endproperty
    property p_quiet; ss_n && $past(ss_n, 4) && ptn_sck_oe |-> !dev_sdo_oe; endproperty
    property p_idle; dev_sck_oe && $past(dev_sck_oe) && ss_n && $past(ss_n) |-> $stable(sck);
    endproperty
    property p_count; $rose(ss_n) |-> cnt_reg == 5'h10; endproperty
    property p_dev_half; dev_sck_oe && !ss_n && $changed(dev_sck_o) |=> $stable(dev_sck_o);
    endproperty
    property p_ptn_half; ptn_sck_oe && !ss_n && $changed(ptn_sck_o) |=> $stable(ptn_sck_o)[*7];
    endproperty
    property p_sel; $fell(ss_n) |-> $stable(sck); endproperty
    a_sck_one: assert property (p_sck_one) else $error("sck clash");
    a_ss_one: assert property (p_ss_one) else $error("select clash");
    a_quiet: assert property (p_quiet) else $error("idle slave drives");
    a_idle: assert property (p_idle) else $error("clock runs idle");
    a_count: assert property (p_count) else $error("edge count");
    a_dev_half: assert property (p_dev_half) else $error("fast clock");
    a_ptn_half: assert property (p_ptn_half) else $error("fast clock");
    a_sel: assert property (p_sel) else $error("select on edge");
    c_dev: cover property ($rose(ss_n) && dev_ss_oe);
    c_ptn: cover property ($rose(ss_n) && ptn_ss_oe);
    c_edge: cover property (!ss_n && $changed(sck));
endmodule

// File: sim/spi_master_slave_port_bench.sv
`timescale 1ns/10ps
`include "syp_consts.svh"
`define CHK(e, g) cmp(e, g)
module spi_master_slave_port_bench;
    // ****
    // Stimulus and design
    // ****
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, slp = 0;
    logic awr, wrr, bv, arr, rv, irq, wake, is_m = 0, cp = 0, ck = 0, ts = 0, rxv, sq;
    logic [7:0] aw = 0, ar = 0, txb = 0, rxb;
    logic [31:0] wd = 0, rdat;
    logic [1:0] br, rr;
    logic [33:0] exp_q[$], rx_q[$];
    int fails = 0, total_checks = 0;
    always #2.5 aclk = ~aclk;
    syp_link_if link();
    syp_port syp_port_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(aw),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .sleep(slp), .irq(irq), .wake(wake), .link(link.dev));
    syp_partner syp_partner_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .is_master(is_m),
        .cpol(cp), .cke(ck), .tx_byte(txb), .tx_start(ts), .rx_byte(rxb), .rx_valid(rxv),
        .busy(), .link(link.ptn));
    syp_monitor syp_monitor_inst (.aclk(aclk), .aresetn(aresetn), .dev_sdo_oe(link.dev_sdo_oe),
        .dev_sck_o(link.dev_sck_o), .dev_sck_oe(link.dev_sck_oe), .dev_ss_oe(link.dev_ss_oe),
        .ptn_sck_o(link.ptn_sck_o), .ptn_sck_oe(link.ptn_sck_oe), .ptn_ss_oe(link.ptn_ss_oe),
        .sck(link.sck), .ss_n(link.ss_n));
    task automatic end_sim();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [33:0] e, input logic [33:0] g);
        total_checks++;
        if (e !== g) begin
            fails++;
            $display("FAIL %0t exp %h got %h", $time, e, g);
        end
    endtask
    // Bounded wait for one edge
    task automatic step(inout int n);
        @(posedge aclk);
        n++;
        if (n > 20000) begin
            fails++;
            end_sim();
        end
    endtask
    // One bus write or read; the answer is checked by the watcher
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [33:0] e);
        int n = 0;
        exp_q.push_back(e);
        {aw, ar, wd, awv, wv, arv, bry, rry} <= {a, a, d, w, w, !w, w, !w};
        do begin
            step(n);
            if (awr) awv <= 1'b0;
            if (wrr) wv <= 1'b0;
            if (arr) arv <= 1'b0;
        end while (bv !== 1'b1 && rv !== 1'b1);
        {bry, rry} <= 2'h0;
        @(posedge aclk);
    endtask
    task automatic pstart(input logic [7:0] b);
        {txb, ts} <= {b, 1'b1};
        @(posedge aclk);
        ts <= 1'b0;
    endtask
    // One byte exchange; m[2] puts the port in slave role
    task automatic xfer(input logic [2:0] m);
        logic [7:0] db, pb;
        logic [31:0] ctl;
        logic sl, c, k, sm;
        int n;
        db = 8'($urandom);
        pb = 8'($urandom);
        c = 1'($urandom);
        sl = m[2];
        k = m[1] ^ m[0];
        // Late sampling in half of the master runs
        sm = m[1] & !m[2];
        n = 0;
        ctl = {26'h1, c, sl ? 4'h4 : 4'(m[0] + 1)};
        bus(1, `SYP_OFS_CTRL, 32'h0, 34'h0);
        {is_m, cp, ck} <= {sl, c, k};
        bus(1, `SYP_OFS_DIR, sl ? 32'hd : 32'h9, 34'h0);
        bus(1, `SYP_OFS_STAT, {24'h0, sm, k, 6'h0}, 34'h0);
        bus(1, `SYP_OFS_CTRL, ctl, 34'h0);
        bus(0, `SYP_OFS_STAT, 0, {26'h0, sm, k, 3'h0, c, 2'h0});
        rx_q.push_back({26'h0, db});
        slp <= sl;
        if (!sl) pstart(pb);
        bus(1, `SYP_OFS_BUF, {24'h0, db}, 34'h0);
        if (sl) pstart(pb);
        else bus(1, `SYP_OFS_BUF, 32'h5a, 34'h0);
        // Byte done and frame closed before the port is touched again
        while (irq !== 1'b1 || link.ss_n !== 1'b1) step(n);
        bus(0, `SYP_OFS_CTRL, 0, {2'h0, ctl | {24'h0, !sl, 7'h0}});
        bus(0, `SYP_OFS_IST, 0, {32'h0, !sl, 1'b1});
        bus(0, `SYP_OFS_BUF, 0, {26'h0, pb});
        bus(1, `SYP_OFS_IST, 32'h3, 34'h0);
        bus(0, `SYP_OFS_IST, 0, 34'h0);
    endtask
    // Watcher: each answer against the oldest note
    always @(posedge aclk) begin
        if (bv === 1'b1 && bry) `CHK(exp_q.pop_front(), {br, 32'h0});
        if (rv === 1'b1 && rry) `CHK(exp_q.pop_front(), {rr, rdat});
        if (rxv === 1'b1) `CHK(rx_q.pop_front(), {26'h0, rxb});
        if (irq === 1'b1 && sq === 1'b1) `CHK(34'h1, {33'h0, wake});
        sq <= slp;
    end
    initial begin
        void'($urandom(32'hc5c0_040b));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        bus(0, `SYP_OFS_DIR, 0, 34'hf);
        bus(0, 8'h40, 0, {2'h2, 32'h0});
        bus(1, 8'h40, 32'h1, {2'h2, 32'h0});
        bus(1, `SYP_OFS_IMASK, 32'h1, 34'h0);
        for (int m = 0; m < 6; m++) xfer(3'(m));
        end_sim();
    end
endmodule
